// ===== hdl/dcsr_consts.vh
// Address map, field positions and reset values of the drive register bank
`ifndef DCSR_CONSTS_VH
`define DCSR_CONSTS_VH

// ======================================================================
// Word addresses
`define DCSR_ADDR_WRITE_ENABLE   16'h0004
`define DCSR_ADDR_RUN_COMMAND    16'h0006
`define DCSR_ADDR_OP_STATUS      16'h000E
`define DCSR_ADDR_TRIP_FLAGS     16'h000F
`define DCSR_ADDR_INPUT_TERM     16'h0010
`define DCSR_ADDR_OUTPUT_TERM    16'h0011
`define DCSR_ADDR_VOLT_ONE       16'h0012
`define DCSR_ADDR_VOLT_TWO       16'h0013
`define DCSR_ADDR_CURRENT_IN     16'h0014
`define DCSR_ADDR_SPEED_RPM      16'h0015
`define DCSR_ADDR_UNIT_SELECT    16'h001A
`define DCSR_ADDR_POLE_COUNT     16'h001B
`define DCSR_ADDR_CUSTOM_VER     16'h001C

// ======================================================================
// Run command word and write enable word fields
`define DCSR_RUN_STOP_BIT        0
`define DCSR_RUN_FWD_BIT         1
`define DCSR_RUN_REV_BIT         2
`define DCSR_WR_ENABLE_BIT       0

// ======================================================================
// Operating status upper fields
`define DCSR_OPS_FWD_BIT         11
`define DCSR_OPS_REV_BIT         12
`define DCSR_OPS_REM_RUN_BIT     13
`define DCSR_OPS_REMOTE_FREQUENCY_SOURCE_BIT    14

// ======================================================================
// Trip word fields
`define DCSR_TRIP_OC_A_BIT       0
`define DCSR_TRIP_OV_BIT         1
`define DCSR_TRIP_EXT_BIT        2
`define DCSR_TRIP_BLOCK_BIT      3
`define DCSR_TRIP_UV_BIT         4
`define DCSR_TRIP_NO_MOTOR_BIT   5
`define DCSR_TRIP_GF_HEAT_BIT    6
`define DCSR_TRIP_THERMAL_BIT    7
`define DCSR_TRIP_OVERLOAD_BIT   8
`define DCSR_TRIP_HARDWARE_DIAGNOSTIC_FAULT_BIT    10
`define DCSR_TRIP_PIPE_BIT       11
`define DCSR_TRIP_OC_B_BIT       12
`define DCSR_TRIP_LEVEL_BIT      13
`define DCSR_TRIP_PHASE_BIT      14
`define DCSR_TRIP_DRV_OVL_BIT    15

// ======================================================================
// Output terminal fields and reset values
`define DCSR_OUT_FAULT_RELAY_BIT 7
`define DCSR_RESET_WORD          16'h0000
`define DCSR_RESET_RUN           3'h0

`endif

// ===== hdl/dcsr_regs.v
// Common-area communication register bank of the motor drive
`timescale 1ns/100ps
// Operation
// - The common-area map is fixed and identical for every model and rating.
// - Operating status bit 11 shows an active forward run, bit 12 an active reverse run.
// - Operating status bit 13 shows remote run source, bit 14 remote frequency source.
// - Trip bits 0 to 6 flag overcurrent, overvoltage, external, block, low volt, no motor, ground.
// - Drive overheat also lands on trip bit 6, shared with ground fault by an OR.
// - Trip bit 7 flags motor thermal overload and bit 8 a general overload.
// - Trip bit 10 flags hardware diagnostic, bit 11 broken pipe, bit 12 second overcurrent.
// - Trip bit 13 flags an under- or over-level detection.
// - Trip bit 14 flags output phase loss and bit 15 drive overload.
// - Output terminal bits 0 to 3 are the relays, bit 7 the fault contact, 4 to 6 zero.
// - A rising write on run command bit 0 issues stop.
// - A rising write on run command bit 1 starts forward running.
// - A rising write on run command bit 2 starts reverse running.
// - The run command word sits at word 0x0006 and reads back bits 2 to 0 of the last accepted write.
`include "dcsr_consts.vh"

module dcsr_regs #(
  parameter [15:0] CUSTOM_VERSION = 16'h0001  // Arbitrary value
) (
  input  wire        clock_in,
  input  wire        arst_n_in,
  // Host register port
  input  wire [15:0] host_addr_in,
  input  wire        host_wr_in,
  input  wire [15:0] host_wdata_in,
  input  wire        host_rd_in,
  output reg  [15:0] host_rdata_out,
  output reg         host_rvalid_out,
  // Drive status from on-chip logic
  input  wire [10:0] op_status_low_in,
  input  wire        remote_run_source_in,
  input  wire        remote_frequency_source_in,
  input  wire        fault_clear_in,
  input  wire        overcurrent_trip_a_in,
  input  wire        overvoltage_trip_in,
  input  wire        external_fault_trip_in,
  input  wire        output_block_in,
  input  wire        undervoltage_trip_in,
  input  wire        no_motor_trip_in,
  input  wire        ground_fault_trip_in,
  input  wire        drive_overheat_trip_in,
  input  wire        motor_thermal_trip_in,
  input  wire        overload_trip_in,
  input  wire        hardware_diagnostic_fault_in,
  input  wire        broken_pipe_trip_in,
  input  wire        overcurrent_trip_b_in,
  input  wire        level_detect_trip_in,
  input  wire        output_phase_loss_in,
  input  wire        drive_overload_trip_in,
  // Terminal pins and drive-side values
  input  wire [7:0]  multifunction_input_in,
  input  wire [3:0]  auxiliary_relay_in,
  input  wire        fault_relay_contact_in,
  input  wire [11:0] voltage_input_one_in,
  input  wire [11:0] voltage_input_two_in,
  input  wire [11:0] current_input_in,
  input  wire [15:0] motor_speed_rpm_in,
  input  wire [15:0] display_unit_select_in,
  input  wire [15:0] motor_pole_count_in,
  // Run commands to the drive
  output reg         stop_cmd_out,
  output reg         forward_run_cmd_out,
  output reg         reverse_run_cmd_out,
  output reg         forward_active_out,
  output reg         reverse_active_out
);

  // ======================================================================
  // Helpers
  function [15:0] dcsr_raw12;
    input [11:0] raw;
    begin
      dcsr_raw12 = {4'h0, raw};
    end
  endfunction

  function dcsr_rise;
    input new_bit;
    input old_bit;
    begin
      dcsr_rise = new_bit & ~old_bit;
    end
  endfunction

  // ======================================================================
  // Terminal input synchronisers
  reg [7:0]  term_meta_reg;
  reg [7:0]  term_sync_reg;

  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      term_meta_reg <= 8'h00;
      term_sync_reg <= 8'h00;
    end else begin
      term_meta_reg <= multifunction_input_in;
      term_sync_reg <= term_meta_reg;
    end
  end

  // ======================================================================
  // Trip word
  reg  [15:0] trip_reg;
  reg  [15:0] trip_next;
  reg  [15:0] trip_event;

  always @* begin
    trip_event = 16'h0000;
    trip_event[`DCSR_TRIP_OC_A_BIT]     = overcurrent_trip_a_in;
    trip_event[`DCSR_TRIP_OV_BIT]       = overvoltage_trip_in;
    trip_event[`DCSR_TRIP_EXT_BIT]      = external_fault_trip_in;
    trip_event[`DCSR_TRIP_BLOCK_BIT]    = output_block_in;
    trip_event[`DCSR_TRIP_UV_BIT]       = undervoltage_trip_in;
    trip_event[`DCSR_TRIP_NO_MOTOR_BIT] = no_motor_trip_in;
    // Two causes share one bit; either one shows
    trip_event[`DCSR_TRIP_GF_HEAT_BIT]  = ground_fault_trip_in |
                                          drive_overheat_trip_in;
    trip_event[`DCSR_TRIP_THERMAL_BIT]  = motor_thermal_trip_in;
    trip_event[`DCSR_TRIP_OVERLOAD_BIT] = overload_trip_in;
    trip_event[`DCSR_TRIP_HARDWARE_DIAGNOSTIC_FAULT_BIT]  = hardware_diagnostic_fault_in;
    trip_event[`DCSR_TRIP_PIPE_BIT]     = broken_pipe_trip_in;
    trip_event[`DCSR_TRIP_OC_B_BIT]     = overcurrent_trip_b_in;
    trip_event[`DCSR_TRIP_LEVEL_BIT]    = level_detect_trip_in;
    trip_event[`DCSR_TRIP_PHASE_BIT]    = output_phase_loss_in;
    trip_event[`DCSR_TRIP_DRV_OVL_BIT]  = drive_overload_trip_in;
  end

  always @* begin
    // Set beats clear so a trip in the clearing cycle is kept
    if (fault_clear_in) begin
      trip_next = trip_event;
    end else begin
      trip_next = trip_reg | trip_event;
    end
  end

  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      trip_reg <= `DCSR_RESET_WORD;
    end else begin
      trip_reg <= trip_next;
    end
  end

  // ======================================================================
  // Write enable and run command word
  reg        wr_armed_reg;
  reg  [2:0] run_word_reg;
  reg  [2:0] run_word_next;
  wire       run_write;
  wire       stop_rise;
  wire       fwd_rise;
  wire       rev_rise;

  // Writes to the run word are dropped until the host arms them
  assign run_write = host_wr_in & wr_armed_reg &
                     (host_addr_in == `DCSR_ADDR_RUN_COMMAND);

  always @* begin
    if (run_write) begin
      run_word_next = host_wdata_in[2:0];
    end else begin
      run_word_next = run_word_reg;
    end
  end

  assign stop_rise = run_write & dcsr_rise(host_wdata_in[`DCSR_RUN_STOP_BIT],
                                            run_word_reg[`DCSR_RUN_STOP_BIT]);
  assign fwd_rise  = run_write & dcsr_rise(host_wdata_in[`DCSR_RUN_FWD_BIT],
                                            run_word_reg[`DCSR_RUN_FWD_BIT]);
  assign rev_rise  = run_write & dcsr_rise(host_wdata_in[`DCSR_RUN_REV_BIT],
                                            run_word_reg[`DCSR_RUN_REV_BIT]);

  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_armed_reg <= 1'b0;
      run_word_reg <= `DCSR_RESET_RUN;
    end else begin
      if (host_wr_in && (host_addr_in == `DCSR_ADDR_WRITE_ENABLE) &&
          host_wdata_in[`DCSR_WR_ENABLE_BIT]) begin
        wr_armed_reg <= 1'b1;
      end
      run_word_reg <= run_word_next;
    end
  end

  // ======================================================================
  // Run state and command pulses
  // Stop wins; forward and reverse together cancel each other
  reg        fwd_active_next;
  reg        rev_active_next;
  wire       any_trip;

  assign any_trip = |trip_next;

  always @* begin
    fwd_active_next = forward_active_out;
    rev_active_next = reverse_active_out;
    if (stop_rise || any_trip) begin
      fwd_active_next = 1'b0;
      rev_active_next = 1'b0;
    end else if (fwd_rise && !rev_rise) begin
      fwd_active_next = 1'b1;
      rev_active_next = 1'b0;
    end else if (rev_rise && !fwd_rise) begin
      fwd_active_next = 1'b0;
      rev_active_next = 1'b1;
    end
  end

  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stop_cmd_out        <= 1'b0;
      forward_run_cmd_out <= 1'b0;
      reverse_run_cmd_out <= 1'b0;
      forward_active_out  <= 1'b0;
      reverse_active_out  <= 1'b0;
    end else begin
      stop_cmd_out        <= stop_rise;
      forward_run_cmd_out <= fwd_rise & ~rev_rise & ~stop_rise;
      reverse_run_cmd_out <= rev_rise & ~fwd_rise & ~stop_rise;
      forward_active_out  <= fwd_active_next;
      reverse_active_out  <= rev_active_next;
    end
  end

  // ======================================================================
  // Read mux
  // Fixed decode with no model straps, so every rating shares one map
  reg  [15:0] rd_word;
  reg  [15:0] op_word;
  reg  [15:0] out_word;

  always @* begin
    op_word = {5'h00, op_status_low_in};
    op_word[`DCSR_OPS_FWD_BIT]      = forward_active_out;
    op_word[`DCSR_OPS_REV_BIT]      = reverse_active_out;
    op_word[`DCSR_OPS_REM_RUN_BIT]  = remote_run_source_in;
    op_word[`DCSR_OPS_REMOTE_FREQUENCY_SOURCE_BIT] = remote_frequency_source_in;
  end

  always @* begin
    out_word = {12'h000, auxiliary_relay_in};
    out_word[`DCSR_OUT_FAULT_RELAY_BIT] = fault_relay_contact_in;
  end

  always @* begin
    case (host_addr_in)
      `DCSR_ADDR_WRITE_ENABLE: rd_word = {15'h0000, wr_armed_reg};
      `DCSR_ADDR_RUN_COMMAND:  rd_word = {13'h0000, run_word_reg};
      `DCSR_ADDR_OP_STATUS:    rd_word = op_word;
      `DCSR_ADDR_TRIP_FLAGS:   rd_word = trip_reg;
      `DCSR_ADDR_INPUT_TERM:   rd_word = {8'h00, term_sync_reg};
      `DCSR_ADDR_OUTPUT_TERM:  rd_word = out_word;
      `DCSR_ADDR_VOLT_ONE:     rd_word = dcsr_raw12(voltage_input_one_in);
      `DCSR_ADDR_VOLT_TWO:     rd_word = dcsr_raw12(voltage_input_two_in);
      `DCSR_ADDR_CURRENT_IN:   rd_word = dcsr_raw12(current_input_in);
      `DCSR_ADDR_SPEED_RPM:    rd_word = motor_speed_rpm_in;
      `DCSR_ADDR_UNIT_SELECT:  rd_word = display_unit_select_in;
      `DCSR_ADDR_POLE_COUNT:   rd_word = motor_pole_count_in;
      `DCSR_ADDR_CUSTOM_VER:   rd_word = CUSTOM_VERSION;
      default:                 rd_word = `DCSR_RESET_WORD;
    endcase
  end

  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      host_rdata_out  <= `DCSR_RESET_WORD;
      host_rvalid_out <= 1'b0;
    end else begin
      host_rvalid_out <= host_rd_in;
      if (host_rd_in) begin
        host_rdata_out <= rd_word;
      end
    end
  end

endmodule // dcsr_regs

// ===== testbench/dcsr_regs_properties.sv
// Concurrent checks on the register bank ports
`timescale 1ns/100ps
module dcsr_regs_properties (
  input wire        clock_in,
  input wire        arst_n_in,
  input wire [15:0] host_addr_in,
  input wire        host_wr_in,
  input wire [15:0] host_wdata_in,
  input wire        host_rd_in,
  input wire        host_rvalid_out,
  input wire        overcurrent_trip_a_in,
  input wire        stop_cmd_out,
  input wire        forward_run_cmd_out,
  input wire        reverse_run_cmd_out,
  input wire        forward_active_out,
  input wire        reverse_active_out
);
  // ==========================================
  // Properties
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  // Command pulses must fall back after one cycle
  sequence s_pulse(sig);
    sig ##1 !sig;
  endsequence
  a_read_answered: assert property (host_rd_in |=> host_rvalid_out)
    else $error("read not answered");
  a_answer_cause: assert property (host_rvalid_out |-> $past(host_rd_in))
    else $error("answer without read");
  a_stop_cause: assert property (stop_cmd_out |-> $past(host_wr_in && host_addr_in == 16'h0006 && host_wdata_in[0]))
    else $error("stop without write");
  a_fwd_cause: assert property (forward_run_cmd_out |-> $past(host_wr_in && host_addr_in == 16'h0006 && host_wdata_in[1]))
    else $error("forward without write");
  a_rev_cause: assert property (reverse_run_cmd_out |-> $past(host_wr_in && host_addr_in == 16'h0006 && host_wdata_in[2]))
    else $error("reverse without write");
  a_stop_pulse: assert property (stop_cmd_out |-> s_pulse(stop_cmd_out))
    else $error("stop pulse too long");
  a_fwd_pulse: assert property (forward_run_cmd_out |-> s_pulse(forward_run_cmd_out))
    else $error("forward pulse too long");
  a_rev_pulse: assert property (reverse_run_cmd_out |-> s_pulse(reverse_run_cmd_out))
    else $error("reverse pulse too long");
  a_fwd_starts: assert property (forward_run_cmd_out && !stop_cmd_out |-> forward_active_out)
    else $error("forward not active");
  a_stop_halts: assert property (stop_cmd_out |-> !forward_active_out && !reverse_active_out)
    else $error("run active after stop");
  a_one_direction: assert property (!(forward_active_out && reverse_active_out))
    else $error("both directions active");
  a_trip_halts: assert property (overcurrent_trip_a_in |=> !forward_active_out)
    else $error("run active after trip");
endmodule // dcsr_regs_properties
bind dcsr_regs dcsr_regs_properties u_props (.clock_in, .arst_n_in, .host_addr_in, .host_wr_in,
  .host_wdata_in, .host_rd_in, .host_rvalid_out, .overcurrent_trip_a_in, .stop_cmd_out,
  .forward_run_cmd_out, .reverse_run_cmd_out, .forward_active_out, .reverse_active_out);

// ===== testbench/dcsr_host_model.sv
// Serial host model issuing register reads and writes
`timescale 1ns/100ps
module dcsr_host_model (
  input  wire        clock_in,
  input  wire [15:0] rdata_in,
  input  wire        rvalid_in,
  output reg  [15:0] addr_out = 16'h0000,
  output reg         wr_out = 1'b0,
  output reg  [15:0] wdata_out = 16'h0000,
  output reg         rd_out = 1'b0
);
  // ==========================================
  // Bus tasks, entered just after an edge
  task write(input [15:0] a, input [15:0] d);
    begin
      addr_out = a;
      wdata_out = d;
      wr_out = 1'b1;
      @(posedge clock_in);
      #2;
      wr_out = 1'b0;
      // Released lines do not keep the last value
      addr_out = ~a;
      wdata_out = ~d;
    end
  endtask
  // Answer stands for one cycle after the taking edge; look before it drops
  task read(input [15:0] a, output [15:0] d, output ok);
    integer i;
    begin
      ok = 1'b0;
      d = 16'h0000;
      addr_out = a;
      rd_out = 1'b1;
      @(posedge clock_in);
      #2;
      rd_out = 1'b0;
      addr_out = ~a;
      for (i = 0; i < 4 && ok !== 1'b1; i = i + 1) begin
        if (rvalid_in === 1'b1) begin
          ok = 1'b1;
          d = rdata_in;
        end
        @(posedge clock_in);
        #2;
      end
    end
  endtask
endmodule // dcsr_host_model

// ===== testbench/dcsr_regs_bench.sv
// Self-checking bench of the drive register bank
`timescale 1ns/100ps
module dcsr_regs_bench;
  reg         clock_in = 1'b0;
  reg         arst_n_in = 1'b0;
  reg  [15:0] trip_v = 16'h0000;
  reg         heat = 1'b0;
  reg         fclr = 1'b0;
  reg  [1:0]  rem = 2'h0;
  reg  [7:0]  mf = 8'h00;
  reg  [4:0]  relays = 5'h00;
  reg  [10:0] ops = 11'h5A5;
  reg  [11:0] v1 = 12'hFFF, v2 = 12'h123, cur = 12'h800;
  reg  [15:0] rpm = 16'h1234, unit = 16'h0001, pole = 16'h0004;
  wire [15:0] addr, wdata, rdata;
  wire        wr, rd, rvalid, stop_c, fwd_c, rev_c, fwd_a, rev_a;
  reg  [2:0]  cmds;
  integer     n_fail = 0;
  integer     samples_checked = 0;
  integer     i;
  always #25 clock_in = ~clock_in;
  dcsr_host_model host (.clock_in(clock_in), .rdata_in(rdata), .rvalid_in(rvalid),
    .addr_out(addr), .wr_out(wr), .wdata_out(wdata), .rd_out(rd));
  dcsr_regs #(.CUSTOM_VERSION(16'h0A5C)) dut (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .host_addr_in(addr), .host_wr_in(wr), .host_wdata_in(wdata), .host_rd_in(rd),
    .host_rdata_out(rdata), .host_rvalid_out(rvalid), .op_status_low_in(ops),
    .remote_run_source_in(rem[0]), .remote_frequency_source_in(rem[1]), .fault_clear_in(fclr),
    .overcurrent_trip_a_in(trip_v[0]), .overvoltage_trip_in(trip_v[1]),
    .external_fault_trip_in(trip_v[2]), .output_block_in(trip_v[3]),
    .undervoltage_trip_in(trip_v[4]), .no_motor_trip_in(trip_v[5]),
    .ground_fault_trip_in(trip_v[6]), .drive_overheat_trip_in(heat),
    .motor_thermal_trip_in(trip_v[7]), .overload_trip_in(trip_v[8]),
    .hardware_diagnostic_fault_in(trip_v[10]), .broken_pipe_trip_in(trip_v[11]),
    .overcurrent_trip_b_in(trip_v[12]), .level_detect_trip_in(trip_v[13]),
    .output_phase_loss_in(trip_v[14]), .drive_overload_trip_in(trip_v[15]),
    .multifunction_input_in(mf), .auxiliary_relay_in(relays[3:0]),
    .fault_relay_contact_in(relays[4]), .voltage_input_one_in(v1), .voltage_input_two_in(v2),
    .current_input_in(cur), .motor_speed_rpm_in(rpm), .display_unit_select_in(unit),
    .motor_pole_count_in(pole), .stop_cmd_out(stop_c), .forward_run_cmd_out(fwd_c),
    .reverse_run_cmd_out(rev_c), .forward_active_out(fwd_a), .reverse_active_out(rev_a));
  // ==========================================
  // Shared tasks
  task complete_run;
    begin
      if (n_fail == 0 && samples_checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task rd_chk(input [15:0] a, input [15:0] exp);
    reg [15:0] d;
    reg        ok;
    begin
      host.read(a, d, ok);
      if (ok !== 1'b1) begin
        n_fail = n_fail + 1;
        complete_run;
      end else begin
        chk(d, exp);
      end
    end
  endtask
  // Idle cycle after each write keeps strobes from toggling twice at once
  // Command pulses stand one cycle after the write edge, so look at once
  task wr_cmd(input [15:0] a, input [15:0] d);
    begin
      host.write(a, d);
      cmds = {stop_c, fwd_c, rev_c};
      @(posedge clock_in);
      #2;
    end
  endtask
  // ==========================================
  // Scenarios
  task t_status;
    begin
      rd_chk(16'h0004, 16'h0000);
      wr_cmd(16'h0006, 16'h0002);
      chk({13'h0, cmds}, 16'h0000);
      rd_chk(16'h0006, 16'h0000);
      rem = 2'h1;
      rd_chk(16'h000E, 16'h25A5);
      rem = 2'h2;
      rd_chk(16'h000E, 16'h45A5);
      rem = 2'h0;
    end
  endtask
  task t_run;
    begin
      wr_cmd(16'h0004, 16'h0001);
      rd_chk(16'h0004, 16'h0001);
      wr_cmd(16'h0006, 16'h0002);
      chk({13'h0, cmds}, 16'h0002);
      chk({14'h0, fwd_a, rev_a}, 16'h0002);
      rd_chk(16'h000E, 16'h0DA5);
      wr_cmd(16'h0006, 16'h0002);
      chk({13'h0, cmds}, 16'h0000);
      wr_cmd(16'h0006, 16'h0004);
      chk({13'h0, cmds}, 16'h0001);
      chk({14'h0, fwd_a, rev_a}, 16'h0001);
      rd_chk(16'h000E, 16'h15A5);
      wr_cmd(16'h0006, 16'h0005);
      chk({13'h0, cmds}, 16'h0004);
      chk({14'h0, fwd_a, rev_a}, 16'h0000);
      rd_chk(16'h000E, 16'h05A5);
      rd_chk(16'h0006, 16'h0005);
      wr_cmd(16'h0006, 16'hFFFA);
      chk({13'h0, cmds}, 16'h0002);
      rd_chk(16'h0006, 16'h0002);
    end
  endtask
  // Reset in mid-run drops the arm, the run word and the run state
  task t_reset;
    begin
      arst_n_in = 1'b0;
      @(posedge clock_in);
      #2;
      chk({10'h0, rvalid, stop_c, fwd_c, rev_c, fwd_a, rev_a}, 16'h0000);
      chk(rdata, 16'h0000);
      arst_n_in = 1'b1;
      @(posedge clock_in);
      #2;
      rd_chk(16'h0004, 16'h0000);
      rd_chk(16'h0006, 16'h0000);
      wr_cmd(16'h0006, 16'h0002);
      chk({13'h0, cmds}, 16'h0000);
      wr_cmd(16'h0004, 16'h0001);
      wr_cmd(16'h0006, 16'h0002);
      chk({13'h0, cmds}, 16'h0002);
    end
  endtask
  task t_trips;
    begin
      for (i = 0; i < 17; i = i + 1) begin
        if (i != 9) begin
          if (i == 16)
            heat = 1'b1;
          else
            trip_v = 16'h0001 << i;
          @(posedge clock_in);
          #2;
          trip_v = 16'h0000;
          heat = 1'b0;
          rd_chk(16'h000F, (i == 16) ? 16'h0040 : 16'h0001 << i);
          fclr = 1'b1;
          @(posedge clock_in);
          #2;
          fclr = 1'b0;
        end
      end
      chk({15'h0, fwd_a}, 16'h0000);
      // Trip and clear in one cycle: the trip must survive
      trip_v = 16'h0008;
      fclr = 1'b1;
      @(posedge clock_in);
      #2;
      trip_v = 16'h0000;
      fclr = 1'b0;
      rd_chk(16'h000F, 16'h0008);
      fclr = 1'b1;
      @(posedge clock_in);
      #2;
      fclr = 1'b0;
      wr_cmd(16'h000F, 16'hFFFF);
      rd_chk(16'h000F, 16'h0000);
    end
  endtask
  task t_terminals;
    begin
      mf = 8'hA5;
      relays = 5'h1A;
      repeat (4) @(posedge clock_in);
      #2;
      rd_chk(16'h0010, 16'h00A5);
      rd_chk(16'h0011, 16'h008A);
      rd_chk(16'h0012, 16'h0FFF);
      rd_chk(16'h0013, 16'h0123);
      rd_chk(16'h0014, 16'h0800);
      rd_chk(16'h0015, 16'h1234);
      rd_chk(16'h001A, 16'h0001);
      rd_chk(16'h001B, 16'h0004);
      rd_chk(16'h001C, 16'h0A5C);
      rd_chk(16'h0016, 16'h0000);
    end
  endtask
  initial begin
    repeat (3) @(posedge clock_in);
    #2;
    arst_n_in = 1'b1;
    @(posedge clock_in);
    #2;
    t_status;
    t_run;
    t_reset;
    t_trips;
    t_terminals;
    complete_run;
  end
endmodule // dcsr_regs_bench
